// >>> ttp_pkg.sv
package ttp_pkg;
   localparam int NUM_CH = 3;
   localparam int CNT_W = 24;
   // ---------------------------------------------------------------
   // register map, one block of four words per channel
   // ---------------------------------------------------------------
   localparam logic [7:0] CH_STRIDE = 8'h10;
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_LOAD = 4'h4;
   localparam logic [3:0] OFF_DUTY = 4'h8;
   localparam logic [3:0] OFF_COUNT = 4'hC;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h34;
   // ---------------------------------------------------------------
   // control/status word fields
   // ---------------------------------------------------------------
   localparam int CTRL_W = 9;
   localparam int BIT_EN = 0;
   localparam int MODE_LSB = 1;
   localparam int MODE_W = 3;
   localparam int BIT_GPIO_DIR = 4;
   localparam int BIT_GPIO_OUT = 5;
   localparam int BIT_EXT_CLK = 6;
   localparam int BIT_TIMER_FN = 7;
   localparam int BIT_PIN_LVL = 8;
   localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
   localparam logic [CNT_W-1:0] LOAD_RST = 24'hFF_FFFF;
   localparam logic [CNT_W-1:0] DUTY_RST = 24'h00_0000;
   localparam logic [NUM_CH-1:0] MASK_RST = 3'h0;
   // ---------------------------------------------------------------
   // channel modes
   // ---------------------------------------------------------------
   localparam logic [MODE_W-1:0] MODE_EVENT = 3'h0;
   localparam logic [MODE_W-1:0] MODE_MEASURE = 3'h1;
   localparam logic [MODE_W-1:0] MODE_TIMER = 3'h2;
   localparam logic [MODE_W-1:0] MODE_WATCHDOG = 3'h3;
   localparam logic [MODE_W-1:0] MODE_PWM = 3'h4;
   // ---------------------------------------------------------------
   // bus slave state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_RDWAIT = 2'b10
   } ttp_bus_st_t;
endpackage

// >>> ttp_ch_if.sv
`timescale 1ns/1ps
// settings flow from the register file into a channel, results flow back
interface ttp_ch_if;
   logic [ttp_pkg::CTRL_W-1:0] ctrl;
   logic ctrl_wr;
   logic [ttp_pkg::CNT_W-1:0] load;
   logic [ttp_pkg::CNT_W-1:0] duty;
   logic pin_lvl;
   logic stop;
   logic [ttp_pkg::CNT_W-1:0] count;
   logic done;
   logic pin_o;
   logic pin_oe;
   modport regs (output ctrl, ctrl_wr, load, duty, pin_lvl, stop,
                 input count, done, pin_o, pin_oe);
   modport chan (input ctrl, ctrl_wr, load, duty, pin_lvl, stop,
                 output count, done, pin_o, pin_oe);
endinterface

// >>> ttp_channel.sv
`timescale 1ns/1ps
module ttp_channel (
   input wire logic hclk,
   input wire logic hresetn,
   ttp_ch_if.chan ch
);
   logic [ttp_pkg::MODE_W-1:0] mode;
   logic en, ext_clk, timer_fn, out_mode, tick, match;
   logic lvl_q, rise, fall;
   logic [ttp_pkg::CNT_W-1:0] cnt_q;
   logic [ttp_pkg::CNT_W-1:0] cap_q;
   logic wd_q;
   logic tog_q;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   assign mode = ch.ctrl[ttp_pkg::MODE_LSB +: ttp_pkg::MODE_W];
   assign en = ch.ctrl[ttp_pkg::BIT_EN];
   assign ext_clk = ch.ctrl[ttp_pkg::BIT_EXT_CLK];
   assign timer_fn = ch.ctrl[ttp_pkg::BIT_TIMER_FN];
   // output-type modes own the pin, input-type modes listen to it
   assign out_mode = (mode == ttp_pkg::MODE_TIMER) ||
                     (mode == ttp_pkg::MODE_WATCHDOG) ||
                     (mode == ttp_pkg::MODE_PWM);
   assign rise = ch.pin_lvl & ~lvl_q;
   assign fall = ~ch.pin_lvl & lvl_q;
   // a tick is a clock, a pin edge, or a clock while the pin is high
   always_comb begin
      if (!en || ch.stop) begin
         tick = 1'b0;
      end else if (mode == ttp_pkg::MODE_MEASURE) begin
         tick = ch.pin_lvl;
      end else if (ext_clk && !out_mode) begin
         tick = rise;
      end else begin
         tick = 1'b1;
      end
   end
   assign match = tick && (cnt_q >= ch.load);

   // pin level history for edge detection, frozen while stopped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lvl_q <= 1'b0;
      end else if (!ch.stop) begin
         lvl_q <= ch.pin_lvl;
      end
   end

   // event counter: cleared by a control write, restarts after a match outside measurement mode, or on a rising pin edge in measurement mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '0;
      end else if (ch.ctrl_wr) begin
         cnt_q <= '0;
      end else if (en && !ch.stop && mode == ttp_pkg::MODE_MEASURE &&
                   rise) begin
         cnt_q <= '0;
      end else if (match && mode != ttp_pkg::MODE_MEASURE) begin
         cnt_q <= '0;
      end else if (tick) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // measurement captures the high time on the falling edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cap_q <= '0;
      end else if (en && !ch.stop && mode == ttp_pkg::MODE_MEASURE &&
                   fall) begin
         cap_q <= cnt_q;
      end
   end

   // completion pulse, one cycle per match or per measured pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ch.done <= 1'b0;
      end else if (mode == ttp_pkg::MODE_MEASURE) begin
         ch.done <= en && !ch.stop && fall;
      end else begin
         ch.done <= match && mode != ttp_pkg::MODE_MEASURE;
      end
   end

   // timer toggles, watchdog latches until the control word is rewritten
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tog_q <= 1'b0;
         wd_q <= 1'b0;
      end else if (ch.ctrl_wr) begin
         tog_q <= 1'b0;
         wd_q <= 1'b0;
      end else if (match) begin
         tog_q <= ~tog_q;
         wd_q <= 1'b1;
      end
   end

   // pin drive; nothing changes while stopped so the last level stays
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ch.pin_o <= 1'b0;
         ch.pin_oe <= 1'b0;
      end else if (!ch.stop) begin
         if (!timer_fn) begin
            ch.pin_oe <= ch.ctrl[ttp_pkg::BIT_GPIO_DIR];
            ch.pin_o <= ch.ctrl[ttp_pkg::BIT_GPIO_OUT];
         end else begin
            ch.pin_oe <= out_mode;
            case (mode)
               ttp_pkg::MODE_TIMER: ch.pin_o <= tog_q;
               ttp_pkg::MODE_WATCHDOG: ch.pin_o <= wd_q;
               ttp_pkg::MODE_PWM: ch.pin_o <= en && (cnt_q < ch.duty);
               default: ch.pin_o <= 1'b0;
            endcase
         end
      end
   end

   // count readback shows the capture in measurement mode
   assign ch.count = (mode == ttp_pkg::MODE_MEASURE) ? cap_q : cnt_q;
endmodule

// >>> ttp_top.sv
`timescale 1ns/1ps
module ttp_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic stop_state,
   input wire logic wait_state,
   input wire logic [2:0] timer_io_pin_i,
   output logic [2:0] timer_io_pin_o,
   output logic [2:0] timer_io_pin_oe,
   output logic timer_irq
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [ttp_pkg::CTRL_W-1:0] ctrl_q [ttp_pkg::NUM_CH];
   logic [ttp_pkg::CNT_W-1:0] load_q [ttp_pkg::NUM_CH];
   logic [ttp_pkg::CNT_W-1:0] duty_q [ttp_pkg::NUM_CH];
   logic [ttp_pkg::NUM_CH-1:0] ctrl_wr_q;
   logic [ttp_pkg::NUM_CH-1:0] status_q;
   logic [ttp_pkg::NUM_CH-1:0] status_d;
   logic [ttp_pkg::NUM_CH-1:0] mask_q;
   logic [ttp_pkg::NUM_CH-1:0] done;
   logic [ttp_pkg::NUM_CH-1:0] sync1_q;
   logic [ttp_pkg::NUM_CH-1:0] sync2_q;
   logic [ttp_pkg::NUM_CH-1:0] pin_o;
   logic [ttp_pkg::NUM_CH-1:0] pin_oe;
   logic [ttp_pkg::CNT_W-1:0] count [ttp_pkg::NUM_CH];
   logic wait_seen;

   // ---------------------------------------------------------------
   // bus slave signals
   // ---------------------------------------------------------------
   ttp_pkg::ttp_bus_st_t bus_q;
   logic addr_ok;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [7:0] rd_addr_q;
   logic [31:0] rd_mux;
   logic wr_now;
   logic [ttp_pkg::NUM_CH-1:0] w1c;

   // wait state is accepted and deliberately has no effect on pins
   assign wait_seen = wait_state;

   // ---------------------------------------------------------------
   // pin input synchronisers and channels
   // ---------------------------------------------------------------
   // two flops before any logic, the second feeds the channel
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= timer_io_pin_i;
         sync2_q <= sync1_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < ttp_pkg::NUM_CH; gi++) begin : g_ch
         ttp_ch_if cif ();
         assign cif.ctrl = ctrl_q[gi];
         assign cif.ctrl_wr = ctrl_wr_q[gi];
         assign cif.load = load_q[gi];
         assign cif.duty = duty_q[gi];
         assign cif.pin_lvl = sync2_q[gi];
         assign cif.stop = stop_state;
         assign count[gi] = cif.count;
         assign done[gi] = cif.done;
         assign pin_o[gi] = cif.pin_o;
         assign pin_oe[gi] = cif.pin_oe;
         // each channel is an independent copy of the same logic
         ttp_channel u_ch (
            .hclk(hclk),
            .hresetn(hresetn),
            .ch(cif.chan)
         );
      end
   endgenerate

   // pins come straight from the channel flops
   assign timer_io_pin_o = pin_o;
   assign timer_io_pin_oe = pin_oe;

   // ---------------------------------------------------------------
   // address phase
   // ---------------------------------------------------------------
   // a transfer is taken when selected, NONSEQ/SEQ and bus ready
   assign addr_ok = hsel && hready && htrans[1];

   // writes finish with no wait; reads take one wait cycle so that a
   // write in the preceding data phase is always visible to them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_q <= ttp_pkg::BUS_IDLE;
         hreadyout <= 1'b1;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rd_addr_q <= 8'h00;
      end else begin
         case (bus_q)
            ttp_pkg::BUS_IDLE: begin
               wr_pend_q <= addr_ok && hwrite;
               if (addr_ok) begin
                  wr_addr_q <= haddr[7:0];
                  rd_addr_q <= haddr[7:0];
               end
               if (addr_ok && !hwrite) begin
                  bus_q <= ttp_pkg::BUS_RDWAIT;
                  hreadyout <= 1'b0;
               end
            end
            ttp_pkg::BUS_RDWAIT: begin
               wr_pend_q <= 1'b0;
               bus_q <= ttp_pkg::BUS_IDLE;
               hreadyout <= 1'b1;
            end
            default: begin
               bus_q <= ttp_pkg::BUS_IDLE;
               hreadyout <= 1'b1;
               wr_pend_q <= 1'b0;
            end
         endcase
      end
   end

   // the slave never reports an error
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
      end
   end

   assign wr_now = wr_pend_q;

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // unmapped and reserved locations read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      for (int i = 0; i < ttp_pkg::NUM_CH; i++) begin
         if (rd_addr_q[7:4] == 4'(i)) begin
            case (rd_addr_q[3:0])
               ttp_pkg::OFF_CTRL: begin
                  rd_mux[ttp_pkg::CTRL_W-1:0] = ctrl_q[i];
                  rd_mux[ttp_pkg::BIT_PIN_LVL] = sync2_q[i];
               end
               ttp_pkg::OFF_LOAD: rd_mux[ttp_pkg::CNT_W-1:0] = load_q[i];
               ttp_pkg::OFF_DUTY: rd_mux[ttp_pkg::CNT_W-1:0] = duty_q[i];
               ttp_pkg::OFF_COUNT: rd_mux[ttp_pkg::CNT_W-1:0] = count[i];
               default: rd_mux = 32'h0000_0000;
            endcase
         end
      end
      if (rd_addr_q == ttp_pkg::OFF_IRQ_STATUS) begin
         rd_mux[ttp_pkg::NUM_CH-1:0] = status_q;
      end
      if (rd_addr_q == ttp_pkg::OFF_IRQ_MASK) begin
         rd_mux[ttp_pkg::NUM_CH-1:0] = mask_q;
      end
   end

   // read data is loaded at the end of the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (bus_q == ttp_pkg::BUS_RDWAIT) begin
         hrdata <= rd_mux;
      end
   end

   // ---------------------------------------------------------------
   // per-channel writable registers
   // ---------------------------------------------------------------
   // the pin level bit is status only and is not stored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < ttp_pkg::NUM_CH; i++) begin
            ctrl_q[i] <= ttp_pkg::CTRL_RST;
            load_q[i] <= ttp_pkg::LOAD_RST;
            duty_q[i] <= ttp_pkg::DUTY_RST;
         end
         ctrl_wr_q <= '0;
      end else begin
         ctrl_wr_q <= '0;
         for (int i = 0; i < ttp_pkg::NUM_CH; i++) begin
            if (wr_now && wr_addr_q[7:4] == 4'(i)) begin
               case (wr_addr_q[3:0])
                  ttp_pkg::OFF_CTRL: begin
                     ctrl_q[i] <= {1'b0,
                        hwdata[ttp_pkg::CTRL_W-2:0]};
                     ctrl_wr_q[i] <= 1'b1;
                  end
                  ttp_pkg::OFF_LOAD:
                     load_q[i] <= hwdata[ttp_pkg::CNT_W-1:0];
                  ttp_pkg::OFF_DUTY:
                     duty_q[i] <= hwdata[ttp_pkg::CNT_W-1:0];
                  default: ;
               endcase
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt status, mask and output
   // ---------------------------------------------------------------
   // writing a one clears a bit, but a new event in that cycle wins
   assign w1c = (wr_now && wr_addr_q == ttp_pkg::OFF_IRQ_STATUS) ?
                hwdata[ttp_pkg::NUM_CH-1:0] : '0;
   assign status_d = (status_q & ~w1c) | done;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_q <= '0;
      end else begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q <= ttp_pkg::MASK_RST;
      end else if (wr_now && wr_addr_q == ttp_pkg::OFF_IRQ_MASK) begin
         mask_q <= hwdata[ttp_pkg::NUM_CH-1:0];
      end
   end

   // registered from the next status so the line follows it exactly
   // one edge later than the event, with no combinational path out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= |(status_d & mask_q);
      end
   end
endmodule

// >>> ttp_top_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the timer pin block
// ----------------------------------------
module ttp_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic stop_state,
   input wire logic [2:0] timer_io_pin_o,
   input wire logic [2:0] timer_io_pin_oe,
   input wire logic timer_irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_tk;
   logic wr_tk;
   logic [2:0] since_q;
   // transfers taken by the slave
   assign rd_tk = hsel & hready & htrans[1] & !hwrite;
   assign wr_tk = hsel & hready & htrans[1] & hwrite;
   // cycles since the last write, saturating so old writes never matter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         since_q <= 3'h7;
      end else if (wr_tk) begin
         since_q <= 3'h0;
      end else if (since_q != 3'h7) begin
         since_q <= since_q + 3'h1;
      end
   end
   property p_rst;
      !$past(hresetn) |-> timer_io_pin_oe == 3'h0 && !timer_irq && hreadyout
         && hrdata == 32'h0000_0000;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_rd_wait;
      rd_tk |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait bad");
   property p_wr_ready;
      wr_tk |=> hreadyout;
   endproperty
   a_wr_ready: assert property (p_wr_ready) else $error("write stall");
   property p_rd_hold;
      hreadyout && $past(hreadyout) |-> $stable(hrdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_oe_cause;
      $changed(timer_io_pin_oe) |-> since_q <= 3'h5;
   endproperty
   a_oe_cause: assert property (p_oe_cause) else $error("dir moved");
   property p_stop_oe;
      stop_state ##1 stop_state |-> $stable(timer_io_pin_oe);
   endproperty
   a_stop_oe: assert property (p_stop_oe) else $error("dir moved stop");
   property p_stop_o;
      stop_state |=> $stable(timer_io_pin_o);
   endproperty
   a_stop_o: assert property (p_stop_o) else $error("pin moved stop");
endmodule
bind ttp_top ttp_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .stop_state(stop_state),
   .timer_io_pin_o(timer_io_pin_o), .timer_io_pin_oe(timer_io_pin_oe),
   .timer_irq(timer_irq));

// >>> ttp_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// outside event sources on the three pins
// ----------------------------------------
module ttp_pin_model (
   input wire logic hclk,
   input wire logic [2:0] pin_o,
   input wire logic [2:0] pin_oe,
   output logic [2:0] pin_i
);
   logic [2:0] src;
   initial src = 3'h0;
   // wire level: the block wins where it drives, the source elsewhere
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & src);
   // n pulses, hi cycles high and hi+1 low; hi of 0 gives no pulse
   task pulse(input int ch, input int n, input int hi);
      repeat (n) begin
         @(posedge hclk);
         src[ch] <= 1'b1;
         repeat (hi) @(posedge hclk);
         src[ch] <= 1'b0;
         repeat (hi) @(posedge hclk);
      end
   endtask
endmodule

// >>> triple_timer_pin_logic_tb_top.sv
`timescale 1ns/1ps
module triple_timer_pin_logic_tb_top;
   logic hclk = 0;
   logic hresetn = 0;
   logic hsel = 0;
   logic hwrite = 0;
   logic stop_state = 0;
   logic wait_state = 0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic timer_irq;
   logic [2:0] pin_i;
   logic [2:0] pin_o;
   logic [2:0] pin_oe;
   int error_cnt = 0;
   int n_checks = 0;
   // 100 ns clock
   always #50 hclk = ~hclk;
   ttp_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .stop_state(stop_state),
      .wait_state(wait_state), .timer_io_pin_i(pin_i),
      .timer_io_pin_o(pin_o), .timer_io_pin_oe(pin_oe),
      .timer_irq(timer_irq));
   ttp_pin_model pm_u (.hclk(hclk), .pin_o(pin_o), .pin_oe(pin_oe),
      .pin_i(pin_i));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task end_sim;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %0t seen %h exp %h", $time, s, e);
      end
   endtask
   // one single transfer; hready is sampled at each edge before moving on
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
      int i;
      i = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && i < 20) begin
         @(posedge hclk);
         i++;
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && i < 20) begin
         @(posedge hclk);
         i++;
      end
      rd = hrdata;
      if (i >= 20) begin
         error_cnt++;
         end_sim;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      chk(d, e);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // edges between two toggles of a pin; bounded so a dead pin ends
   task per(input int ch, output int n);
      logic v;
      int i;
      i = 0;
      v = pin_o[ch];
      while (pin_o[ch] === v && i < 60) begin
         @(posedge hclk);
         i++;
      end
      v = pin_o[ch];
      n = 0;
      while (pin_o[ch] === v && n < 60) begin
         @(posedge hclk);
         n++;
      end
      // a pin that never toggles is a failure, not a silent short count
      if (i >= 60 || n >= 60) begin
         error_cnt++;
         end_sim;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      chk(32'(pin_oe), 32'h0);
      chk(32'(timer_irq), 32'h0);
      rdc(8'h00, 32'h0);
      rdc(8'h14, 32'h00ff_ffff);
      rdc(8'h28, 32'h0);
      rdc(8'h34, 32'h0);
      rdc(8'h38, 32'h0);
   endtask
   task t_timer;
      int n;
      wr(8'h04, 32'h4);
      wr(8'h34, 32'h1);
      wr(8'h00, 32'h85);
      wait_state <= 1'b1;
      cyc(3);
      chk(32'(pin_oe[0]), 32'h1);
      per(0, n);
      chk(32'(n), 32'h5);
      per(0, n);
      chk(32'(n), 32'h5);
      chk(32'(timer_irq), 32'h1);
      rdc(8'h30, 32'h1);
      wr(8'h34, 32'h0);
      cyc(2);
      chk(32'(timer_irq), 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h30, 32'h1);
      rdc(8'h30, 32'h0);
      wait_state <= 1'b0;
      wr(8'h00, 32'h05);
      cyc(8);
      chk(32'(pin_oe[0]), 32'h0);
      // stop channel 0 so its matches do not leak into later status reads
      wr(8'h00, 32'h0);
      wr(8'h30, 32'h1);
   endtask
   task t_event;
      wr(8'h10, 32'hc1);
      cyc(3);
      chk(32'(pin_oe[1]), 32'h0);
      pm_u.pulse(1, 4, 3);
      cyc(4);
      rdc(8'h1c, 32'h4);
      @(posedge hclk);
      stop_state <= 1'b1;
      pm_u.pulse(1, 2, 2);
      cyc(4);
      stop_state <= 1'b0;
      cyc(4);
      rdc(8'h1c, 32'h4);
      wr(8'h10, 32'h0);
      wr(8'h20, 32'h83);
      cyc(3);
      chk(32'(pin_oe[2]), 32'h0);
      pm_u.pulse(2, 1, 3);
      cyc(4);
      rdc(8'h30, 32'h4);
      wr(8'h20, 32'h0);
      wr(8'h30, 32'h7);
   endtask
   task t_gpio;
      wr(8'h10, 32'h30);
      cyc(3);
      chk(32'(pin_oe[1]), 32'h1);
      chk(32'(pin_o[1]), 32'h1);
      wr(8'h10, 32'h10);
      cyc(3);
      chk(32'(pin_o[1]), 32'h0);
      wr(8'h10, 32'h0);
      pm_u.src[1] <= 1'b1;
      cyc(4);
      rdc(8'h10, 32'h100);
      pm_u.src[1] <= 1'b0;
   endtask
   task t_pwm;
      int h;
      h = 0;
      wr(8'h24, 32'h4);
      wr(8'h28, 32'h2);
      wr(8'h20, 32'h89);
      cyc(5);
      repeat (10) begin
         @(posedge hclk);
         h += int'(pin_o[2]);
      end
      chk(32'(h), 32'h4);
      wr(8'h20, 32'h0);
   endtask
   task t_wd_stop;
      logic [2:0] v;
      wr(8'h04, 32'h3);
      wr(8'h00, 32'h87);
      cyc(12);
      chk(32'(pin_o[0]), 32'h1);
      cyc(20);
      chk(32'(pin_o[0]), 32'h1);
      wr(8'h00, 32'h85);
      cyc(6);
      stop_state <= 1'b1;
      @(posedge hclk);
      v = pin_o;
      cyc(12);
      chk(32'(pin_o), 32'(v));
      chk(32'(pin_oe[0]), 32'h1);
      stop_state <= 1'b0;
      wr(8'h10, 32'h30);
      cyc(3);
      hresetn <= 1'b0;
      cyc(2);
      chk(32'(pin_oe), 32'h0);
      hresetn <= 1'b1;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_timer;
      t_event;
      t_gpio;
      t_pwm;
      t_wd_stop;
      cyc(2);
      end_sim;
   end
endmodule
